// file: common/qcount_pkg.sv
package qcount_pkg;
   // ****************************************************************
   // Register map, word aligned byte addresses
   // ****************************************************************
   localparam logic [4:0] ADDR_PRESET_BYTE = 5'h00;
   localparam logic [4:0] ADDR_COMPARE_BYTE = 5'h04;
   localparam logic [4:0] ADDR_CONFIG = 5'h08;
   localparam logic [4:0] ADDR_COMMAND = 5'h0C;
   localparam logic [4:0] ADDR_COUNT = 5'h10;
   localparam logic [4:0] ADDR_STATUS = 5'h14;
   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_GATE_LSB = 4;
   localparam int CFG_MATCH_LSB = 6;
   localparam int CFG_A_LSB = 8;
   localparam int CFG_B_BIT = 10;
   localparam int CMD_START_BIT = 0;
   localparam int CMD_PTR_RST_BIT = 1;
   localparam int ST_MATCH_BIT = 0;
   localparam int ST_GATE_BIT = 1;
   localparam int ST_DIR_BIT = 2;
   // ****************************************************************
   // Reset values and timing
   // ****************************************************************
   localparam logic [10:0] CONFIG_RESET = 11'h000;
   localparam int CLK_HZ = 40_000_000;
   localparam int PULSE_MIN_US = 25;
   localparam int PULSE_CYCLES = (PULSE_MIN_US * (CLK_HZ / 1_000_000));
   // ****************************************************************
   // Modes
   // ****************************************************************
   localparam logic [2:0] MODE_SINGLE_A = 3'h0;
   localparam logic [2:0] MODE_SINGLE_B = 3'h1;
   localparam logic [2:0] MODE_DOUBLE = 3'h2;
   localparam logic [2:0] MODE_TRIPLE = 3'h3;
   localparam logic [2:0] MODE_FOUR = 3'h4;
   localparam logic [1:0] GATE_HIGH = 2'h0;
   localparam logic [1:0] GATE_LOW = 2'h1;
   localparam logic [1:0] GATE_RISE = 2'h2;
   localparam logic [1:0] GATE_FALL = 2'h3;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } bus_state_t;
endpackage

// file: rtl/quadrature_count_direction_counter.sv
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
// How it works
// - 24-bit counter loaded from preset register.
// - Start copies preset, counts, arms match output.
// - Host reads count, match, gate, direction.
// - Gate mode 0 counts while input high.
// - Gate mode 1 counts while input low.
// - Gate mode 2 toggles on rising edges.
// - Gate mode 3 toggles on falling edges.
// - Match mode 0 low, latches high.
// - Match mode 1 high, latches low.
// - Match mode 2 idles low, high pulses.
// - Match mode 3 idles high, low pulses.
// - Two-bit phase A inversion setting.
// - Single-edge direction from phase B, invertible.
// - Modes 0,1 count rising A edges only.
// - Count wraps modulo two to twenty-four.
// - Mode 2 counts both A edges.
// - Mode 4 counts all edges.
// - Mode 3 accepted, triple-edge behaviour chosen.
// - Inverting one phase reverses direction.
module quadrature_count_direction_counter #(
   parameter int WIDTH = 24,
   parameter int PULSE_LEN = qcount_pkg::PULSE_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic i_phase_a,
   input wire logic i_phase_b,
   input wire logic i_count_gate_input,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic o_match_output,
   output logic [WIDTH-1:0] o_count
);
   if (WIDTH != 24) begin : g_width_check
      $error("Counter width must be 24.");
   end
   if (PULSE_LEN < 1 || PULSE_LEN > 65535) begin : g_pulse_check
      $error("Pulse length out of range.");
   end

   typedef struct packed {
      qcount_pkg::bus_state_t bus;
      logic wait_req;
      logic [31:0] rdata;
      logic [23:0] preset;
      logic [23:0] compare;
      logic [1:0] preset_ptr;
      logic [1:0] compare_ptr;
      logic [10:0] cfg;
      logic [23:0] count;
      logic started;
      logic gate_toggle;
      logic dir;
      logic match_out;
      logic match_prev;
      logic [15:0] pulse_cnt;
      logic [2:0] a_sync;
      logic [2:0] b_sync;
      logic [2:0] g_sync;
   } state_t;

   state_t r;
   state_t next_r;

   logic a_in;
   logic b_in;
   logic a_prev;
   logic b_prev;
   logic g_in;
   logic g_prev;
   logic rise_a;
   logic fall_a;
   logic edge_b;
   logic step;
   logic quad_dir;
   logic gate_on;
   logic equal;
   logic start_cmd;
   logic [2:0] mode;
   logic [1:0] gate_mode;
   logic [1:0] match_mode;
   logic dyn_match;
   logic idle_level;
   logic acc;
   logic wr_fire;

   always_comb begin
      next_r = r;
      mode = r.cfg[qcount_pkg::CFG_MODE_LSB +: 3];
      gate_mode = r.cfg[qcount_pkg::CFG_GATE_LSB +: 2];
      match_mode = r.cfg[qcount_pkg::CFG_MATCH_LSB +: 2];
      dyn_match = match_mode[1];
      idle_level = match_mode[0];
      // ****************************************************************
      // Input conditioning
      // ****************************************************************
      // two-stage synchronisers
      next_r.a_sync = {r.a_sync[1:0], i_phase_a};
      next_r.b_sync = {r.b_sync[1:0], i_phase_b};
      next_r.g_sync = {r.g_sync[1:0], i_count_gate_input};
      a_in = r.a_sync[1] ^ r.cfg[qcount_pkg::CFG_A_LSB];
      a_prev = r.a_sync[2] ^ r.cfg[qcount_pkg::CFG_A_LSB];
      b_in = r.b_sync[1] ^ r.cfg[qcount_pkg::CFG_B_BIT];
      b_prev = r.b_sync[2] ^ r.cfg[qcount_pkg::CFG_B_BIT];
      g_in = r.g_sync[1];
      g_prev = r.g_sync[2];
      rise_a = a_in & ~a_prev;
      fall_a = ~a_in & a_prev;
      edge_b = b_in ^ b_prev;
      quad_dir = (a_in ^ a_prev) ? (a_in ^ b_in) : ~(a_in ^ b_in);
      // triple mode counts both A edges and B rising
      case (mode)
         qcount_pkg::MODE_SINGLE_A, qcount_pkg::MODE_SINGLE_B: begin
            step = rise_a;
         end
         qcount_pkg::MODE_DOUBLE: begin
            step = rise_a | fall_a;
         end
         qcount_pkg::MODE_TRIPLE: begin
            step = rise_a | fall_a | (edge_b & b_in);
         end
         qcount_pkg::MODE_FOUR: begin
            step = rise_a | fall_a | edge_b;
         end
         default: begin
            step = 1'b0;
         end
      endcase
      if (mode == qcount_pkg::MODE_SINGLE_A || mode == qcount_pkg::MODE_SINGLE_B) begin
         next_r.dir = b_in;
      end else if (step) begin
         next_r.dir = quad_dir;
      end
      // ****************************************************************
      // Counting gate
      // ****************************************************************
      case (gate_mode)
         qcount_pkg::GATE_HIGH: gate_on = g_in;
         qcount_pkg::GATE_LOW: gate_on = ~g_in;
         default: gate_on = r.gate_toggle;
      endcase
      if (gate_mode == qcount_pkg::GATE_RISE && g_in && !g_prev) begin
         next_r.gate_toggle = ~r.gate_toggle;
      end
      if (gate_mode == qcount_pkg::GATE_FALL && !g_in && g_prev) begin
         next_r.gate_toggle = ~r.gate_toggle;
      end
      if (step && gate_on && r.started) begin
         if (next_r.dir) begin
            next_r.count = r.count + 24'h000001;
         end else begin
            next_r.count = r.count - 24'h000001;
         end
      end
      // ****************************************************************
      // Match output
      // ****************************************************************
      // compare every cycle
      equal = r.started && (r.count == r.compare);
      next_r.match_prev = equal;
      if (r.pulse_cnt != 16'h0000) begin
         next_r.pulse_cnt = r.pulse_cnt - 16'h0001;
         if (r.pulse_cnt == 16'h0001) begin
            next_r.match_out = idle_level;
         end
      end
      if (equal && !r.match_prev) begin
         next_r.match_out = ~idle_level;
         if (dyn_match) begin
            next_r.pulse_cnt = 16'(PULSE_LEN);
         end
      end
      // ****************************************************************
      // Avalon slave, one wait state per access
      // ****************************************************************
      start_cmd = 1'b0;
      acc = (i_avs_read | i_avs_write) && r.bus == qcount_pkg::BUS_IDLE;
      // Writes act at the completing edge, when the master sees waitrequest low.
      wr_fire = i_avs_write && r.bus == qcount_pkg::BUS_ACK;
      // Registering waitrequest keeps it high outside answer cycles, which the bus allows.
      next_r.wait_req = ~acc;
      case (r.bus)
         qcount_pkg::BUS_IDLE: begin
            if (acc) begin
               next_r.bus = qcount_pkg::BUS_ACK;
            end
         end
         qcount_pkg::BUS_ACK: begin
            next_r.bus = qcount_pkg::BUS_IDLE;
         end
         default: begin
            next_r.bus = qcount_pkg::BUS_IDLE;
         end
      endcase
      if (wr_fire && i_avs_byteenable[0]) begin
         case (i_avs_address)
            qcount_pkg::ADDR_PRESET_BYTE: begin
               next_r.preset[8*r.preset_ptr +: 8] = i_avs_writedata[7:0];
               next_r.preset_ptr = (r.preset_ptr == 2'h2) ? 2'h0 : r.preset_ptr + 2'h1;
            end
            qcount_pkg::ADDR_COMPARE_BYTE: begin
               next_r.compare[8*r.compare_ptr +: 8] = i_avs_writedata[7:0];
               next_r.compare_ptr = (r.compare_ptr == 2'h2) ? 2'h0 : r.compare_ptr + 2'h1;
            end
            qcount_pkg::ADDR_CONFIG: begin
               if (i_avs_byteenable[1]) begin
                  next_r.cfg = i_avs_writedata[10:0];
                  next_r.gate_toggle = 1'b0;
               end
            end
            qcount_pkg::ADDR_COMMAND: begin
               start_cmd = i_avs_writedata[qcount_pkg::CMD_START_BIT];
               if (i_avs_writedata[qcount_pkg::CMD_PTR_RST_BIT]) begin
                  next_r.preset_ptr = 2'h0;
                  next_r.compare_ptr = 2'h0;
               end
            end
            default: begin
            end
         endcase
      end
      if (start_cmd) begin
         next_r.count = r.preset;
         next_r.started = 1'b1;
         next_r.match_out = idle_level;
         next_r.pulse_cnt = 16'h0000;
         next_r.match_prev = 1'b1;
      end
      if (acc && i_avs_read) begin
         case (i_avs_address)
            qcount_pkg::ADDR_PRESET_BYTE: next_r.rdata = {8'h00, r.preset};
            qcount_pkg::ADDR_COMPARE_BYTE: next_r.rdata = {8'h00, r.compare};
            qcount_pkg::ADDR_CONFIG: next_r.rdata = {21'h000000, r.cfg};
            qcount_pkg::ADDR_COUNT: next_r.rdata = {8'h00, r.count};
            qcount_pkg::ADDR_STATUS: next_r.rdata = {29'h00000000, r.dir,
               gate_on & r.started, r.match_out};
            default: next_r.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         r <= '{bus: qcount_pkg::BUS_IDLE, wait_req: 1'b1, cfg: qcount_pkg::CONFIG_RESET,
            default: '0};
      end else begin
         r <= next_r;
      end
   end

   assign o_avs_readdata = r.rdata;
   assign o_avs_waitrequest = r.wait_req;
   assign o_match_output = r.match_out;
   assign o_count = r.count;

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_start_loads: assert property (@(posedge i_clk) disable iff (!i_nrst)
      start_cmd |=> r.count == $past(r.preset) && r.started)
      else $error("Start did not load preset.");
   a_wrap_down: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (step && gate_on && r.started && !next_r.dir && r.count == 24'h000000 && !start_cmd)
      |=> r.count == 24'hFFFFFF)
      else $error("Down count from zero did not wrap.");
   a_hold_gate: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (!gate_on && !start_cmd) |=> $stable(r.count))
      else $error("Count moved while gated off.");
   a_pulse_len: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (dyn_match && r.pulse_cnt == 16'(PULSE_LEN) && !start_cmd && $stable(r.cfg))
      |-> r.match_out != idle_level)
      else $error("Match pulse missing.");
   a_static_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (!dyn_match && r.match_out != idle_level && !start_cmd && next_r.cfg == r.cfg)
      |=> r.match_out != idle_level)
      else $error("Static match output released.");
   a_single_dir: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (mode[2:1] == 2'b00) |=> r.dir == $past(b_in))
      else $error("Single-edge direction wrong.");
   a_single_edge: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (mode[2:1] == 2'b00 && !rise_a && !start_cmd) |=> $stable(r.count))
      else $error("Counted without rising edge.");
   a_wait_once: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_avs_read && r.bus == qcount_pkg::BUS_IDLE) |=> !o_avs_waitrequest)
      else $error("Read not answered in one cycle.");
   a_gate_low: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (gate_mode == qcount_pkg::GATE_LOW && g_in && !start_cmd) |=> $stable(r.count))
      else $error("Count moved while gate input high.");
   a_toggle_rise: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (gate_mode == qcount_pkg::GATE_RISE && g_in && !g_prev && !wr_fire)
      |=> r.gate_toggle != $past(r.gate_toggle))
      else $error("Rising gate edge did not toggle counting.");
   a_toggle_fall: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (gate_mode == qcount_pkg::GATE_FALL && !g_in && g_prev && !wr_fire)
      |=> r.gate_toggle != $past(r.gate_toggle))
      else $error("Falling gate edge did not toggle counting.");
   a_start_idle: assert property (@(posedge i_clk) disable iff (!i_nrst)
      start_cmd |=> r.match_out == $past(idle_level))
      else $error("Start did not arm the match output.");
   a_no_start: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (!r.started && !start_cmd) |=> $stable(r.count))
      else $error("Count moved before a start.");
   a_match_sets: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (equal && !r.match_prev && !start_cmd) |=> r.match_out != $past(idle_level))
      else $error("Equality did not switch the match output.");
   a_pulse_end: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (r.pulse_cnt == 16'h0001 && !start_cmd && !(equal && !r.match_prev))
      |=> r.match_out == $past(idle_level))
      else $error("Match pulse did not end.");
   a_wrap_up: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (step && gate_on && r.started && next_r.dir && r.count == 24'hFFFFFF && !start_cmd)
      |=> r.count == 24'h000000)
      else $error("Up count from maximum did not wrap.");
   a_double_dir: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (mode == qcount_pkg::MODE_DOUBLE && ((rise_a && !b_in) || (fall_a && b_in)))
      |=> r.dir)
      else $error("Leading phase A did not count up.");
   a_four_dir: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (mode == qcount_pkg::MODE_FOUR && edge_b && !rise_a && !fall_a && b_in == a_in)
      |=> r.dir)
      else $error("Lagging phase B edge did not count up.");
   a_triple_fall: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (mode == qcount_pkg::MODE_TRIPLE && edge_b && !b_in && !rise_a && !fall_a && !start_cmd)
      |=> $stable(r.count))
      else $error("Triple mode counted a falling B edge.");
   a_preset_byte: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (wr_fire && i_avs_byteenable[0] && i_avs_address == qcount_pkg::ADDR_PRESET_BYTE
      && r.preset_ptr == 2'h0) |=> r.preset[7:0] == $past(i_avs_writedata[7:0]))
      else $error("Preset low byte not taken.");
   a_read_count: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_avs_read && r.bus == qcount_pkg::BUS_IDLE && i_avs_address == qcount_pkg::ADDR_COUNT)
      |=> o_avs_readdata == {8'h00, $past(r.count)})
      else $error("Count readback wrong.");
   a_status_bits: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_avs_read && r.bus == qcount_pkg::BUS_IDLE && i_avs_address == qcount_pkg::ADDR_STATUS)
      |=> o_avs_readdata[qcount_pkg::ST_DIR_BIT] == $past(r.dir)
      && o_avs_readdata[qcount_pkg::ST_MATCH_BIT] == $past(r.match_out))
      else $error("Status readback wrong.");

   // ****************************************************************
   // Scenario coverage
   // ****************************************************************
   c_start: cover property (@(posedge i_clk) disable iff (!i_nrst) start_cmd);
   c_match: cover property (@(posedge i_clk) disable iff (!i_nrst) equal && !r.match_prev);
   c_wrap: cover property (@(posedge i_clk) disable iff (!i_nrst) r.count == 24'hFFFFFF);
   c_pulse_end: cover property (@(posedge i_clk) disable iff (!i_nrst) r.pulse_cnt == 16'h0001);
   c_quad_back: cover property (@(posedge i_clk) disable iff (!i_nrst)
      mode == qcount_pkg::MODE_FOUR && step && !quad_dir);
endmodule

// file: testbench/encoder_model.sv
`timescale 1ns/1ps
module encoder_model (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_move,
   input wire logic i_back,
   input wire logic i_pulse_mode,
   input wire logic i_b_level,
   output logic o_phase_a,
   output logic o_phase_b
);
   // ****************************************************************
   // Pulse source or two-phase shaft encoder
   // ****************************************************************
   // In pulse mode each move toggles phase A and phase B follows the level input.
   // In encoder mode a forward move lets phase A lead B by a quarter cycle.
   // In encoder mode only one phase changes per move, as on a real encoder.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_phase_a <= 1'b0;
         o_phase_b <= 1'b0;
      end else if (i_pulse_mode) begin
         o_phase_b <= i_b_level;
         if (i_move) begin
            o_phase_a <= ~o_phase_a;
         end
      end else if (i_move) begin
         if ((o_phase_a == o_phase_b) != i_back) begin
            o_phase_a <= ~o_phase_a;
         end else begin
            o_phase_b <= ~o_phase_b;
         end
      end
   end
endmodule

// file: testbench/quadrature_count_direction_counter_test.sv
`timescale 1ns/1ps
module quadrature_count_direction_counter_test;
   localparam int PULSE_SIM = 40;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [4:0] addr = 5'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic gate = 1'b0;
   logic move = 1'b0;
   logic back = 1'b0;
   logic pmode = 1'b1;
   logic blevel = 1'b0;
   logic pa, pb, wait_req, match;
   logic [31:0] rdata;
   logic [23:0] count;
   int failures = 0;
   int checks = 0;
   logic [3:0] gtab [4] = '{4'h2, 4'hD, 4'hE, 4'h1};
   logic [2:0] qm [5] = '{3'h2, 3'h4, 3'h3, 3'h4, 3'h2};
   logic [1:0] qa [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h0};
   logic qb [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   logic [23:0] qd [5] = '{24'h000002, 24'h000004, 24'h000003, 24'hFFFFFC, 24'hFFFFFE};

   quadrature_count_direction_counter #(.PULSE_LEN(PULSE_SIM)) u_quadrature_count_direction_counter (
      .i_clk(clk), .i_nrst(nrst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .i_phase_a(pa), .i_phase_b(pb),
      .i_count_gate_input(gate), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
      .o_match_output(match), .o_count(count));

   encoder_model u_encoder_model (
      .i_clk(clk), .i_nrst(nrst), .i_move(move), .i_back(back), .i_pulse_mode(pmode),
      .i_b_level(blevel), .o_phase_a(pa), .o_phase_b(pb));

   initial begin
      forever #12.5 clk = ~clk;
   end

   // ****************************************************************
   // Bus and stimulus tasks
   // ****************************************************************
   task check(input logic [31:0] seen, input logic [31:0] want);
      checks++;
      if (seen !== want) begin
         failures++;
         $display("wrong value at %0t: got %h, expected %h", $time, seen, want);
      end
   endtask

   // The request stands until the edge at which waitrequest is seen low; read data is taken there.
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      rd <= ~w;
      wr <= w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wait_req !== 1'b0 && n < 50);
      q = rdata;
      if (wait_req !== 1'b0) begin
         failures++;
      end
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task wr_reg(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task rd_chk(input logic [4:0] a, input logic [31:0] want);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, want);
   endtask

   task step(input logic bk);
      @(posedge clk);
      move <= 1'b1;
      back <= bk;
      @(posedge clk);
      move <= 1'b0;
      repeat (6) @(posedge clk);
   endtask

   task pulse;
      step(1'b0);
      step(1'b0);
   endtask

   function automatic logic [10:0] cfgv(logic [2:0] m, logic [1:0] g, logic [1:0] c,
                                        logic [1:0] a, logic b);
      return {b, a, c, g, 1'b0, m};
   endfunction

   task setup(input logic [10:0] cfg, input logic [23:0] pre, input logic [23:0] cmp);
      wr_reg(qcount_pkg::ADDR_COMMAND, 32'h2);
      for (int i = 0; i < 3; i++) begin
         wr_reg(qcount_pkg::ADDR_PRESET_BYTE, {24'h0, pre[8*i+:8]});
         wr_reg(qcount_pkg::ADDR_COMPARE_BYTE, {24'h0, cmp[8*i+:8]});
      end
      wr_reg(qcount_pkg::ADDR_CONFIG, {21'h0, cfg});
      wr_reg(qcount_pkg::ADDR_COMMAND, 32'h1);
      repeat (4) @(posedge clk);
   endtask

   task tally_and_finish;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      logic [23:0] want;
      logic idle;
      logic act;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      check(count, 24'h0);
      check(match, 1'b0);
      rd_chk(qcount_pkg::ADDR_STATUS, 32'h0);
      rd_chk(5'h18, 32'h0);
      gate <= 1'b1;
      setup(cfgv(qcount_pkg::MODE_SINGLE_A, 2'h0, 2'h0, 2'h0, 1'b0), 24'h000002, 24'hABCDEF);
      check(count, 24'h000002);
      rd_chk(qcount_pkg::ADDR_PRESET_BYTE, 32'h000002);
      rd_chk(qcount_pkg::ADDR_COMPARE_BYTE, 32'hABCDEF);
      want = 24'h000002;
      for (int i = 0; i < 3; i++) begin
         step(1'b0);
         want = want - 24'h1;
         check(count, want);
         step(1'b0);
         check(count, want);
      end
      rd_chk(qcount_pkg::ADDR_COUNT, 32'hFFFFFF);
      rd_chk(qcount_pkg::ADDR_STATUS, 32'h2);
      setup(cfgv(qcount_pkg::MODE_SINGLE_B, 2'h0, 2'h0, 2'h0, 1'b1), 24'hFFFFFF, 24'hABCDEF);
      pulse;
      check(count, 24'h0);
      blevel <= 1'b1;
      pulse;
      check(count, 24'hFFFFFF);
      // Gate modes 0 to 2 start with the gate pin low and mode 3 starts with it high; the table holds which pulses count.
      for (int g = 0; g < 4; g++) begin
         gate <= (g == 3);
         setup(cfgv(qcount_pkg::MODE_SINGLE_A, 2'(g), 2'h0, 2'h0, 1'b0), 24'h0, 24'hABCDEF);
         want = 24'h0;
         for (int k = 0; k < 4; k++) begin
            if (k > 0) begin
               gate <= ~gate;
               repeat (4) @(posedge clk);
            end
            pulse;
            want = want + 24'(gtab[k][g]);
            check(count, want);
         end
      end
      gate <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         idle = (m % 2 == 1);
         act = ~idle;
         setup(cfgv(qcount_pkg::MODE_SINGLE_A, 2'h0, 2'(m), 2'h0, 1'b0), 24'h0, 24'h000002);
         check(match, idle);
         pulse;
         pulse;
         check(match, act);
         rd_chk(qcount_pkg::ADDR_STATUS, {29'h0, 2'b11, act});
         repeat (PULSE_SIM + 10) @(posedge clk);
         check(match, (m >= 2) ? idle : act);
         pulse;
         blevel <= 1'b0;
         pulse;
         check(match, act);
         blevel <= 1'b1;
      end
      blevel <= 1'b0;
      repeat (2) @(posedge clk);
      pmode <= 1'b0;
      for (int r = 0; r < 5; r++) begin
         setup(cfgv(qm[r], 2'h0, 2'h0, qa[r], qb[r]), 24'h000010, 24'hABCDEF);
         repeat (4) step(1'b0);
         check(count, 24'(24'h000010 + qd[r]));
         if (r < 3) begin
            repeat (4) step(1'b1);
            check(count, 24'h000010);
         end
      end
      tally_and_finish;
   end

   // The full sequence needs about 1600 cycles; this bound only catches a hang.
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      tally_and_finish;
   end
endmodule
